// ### logic/bcd_digit_step.sv
// Two-digit BCD increment with wrap to a minimum past a maximum
`timescale 1ns/1ps
`default_nettype none
module bcd_digit_step (
    input  wire logic [7:0] value,
    input  wire logic [7:0] max_value,
    input  wire logic [7:0] min_value,
    output logic      [7:0] next_value,
    output logic            wrap
);
    wire        units_nine = (value[3:0] == 4'h9);
    wire [3:0]  units_inc  = 4'(value[3:0] + 4'h1);
    wire [3:0]  tens_inc   = 4'(value[7:4] + 4'h1);
    wire [7:0]  plain_inc  = units_nine ? {tens_inc, 4'h0} : {value[7:4], units_inc};

    assign wrap       = (value >= max_value);
    assign next_value = wrap ? min_value : plain_inc;
endmodule
`default_nettype wire

// ### logic/bcd_time_of_day_counters.sv
// Top of the BCD time-of-day counter chain with its AHB-Lite register slave
// Operation
// - Every counter except the weekday holds tens and units as separate BCD digit groups.
// - Seconds at index 08h count 0 to 59 in bits 6..0, bit 7 unused.
// - Minutes at index 09h count 0 to 59 in bits 6..0, bit 7 unused.
// - Hours at index 0Ah with bit 6 set count 1 to 12 in bits 4..0 with bit 5 as afternoon flag.
// - Hours with bit 6 clear count 0 to 23 in BCD in bits 5..0.
// - Day of month at index 0Bh counts 1 to 31 in bits 5..0, bits 7..6 unused.
// - February has a 29th day whenever the year value is divisible by 4, year 00 included.
// - Weekday at index 0Ch counts 1 to 7 in bits 2..0, Sunday being 1 by default.
// - Unimplemented bits of the counter registers read as zero.
// - The month counter takes the day carry and counts 1 to 12 in bits 4..0.
// - The year counter counts 0 to 79 in bits 6..0 for years 2000 onward.
`timescale 1ns/1ps
`default_nettype none
module bcd_time_of_day_counters #(
    parameter longint TICK_CYCLES = rtc_count_pkg::TICK_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             second_tick
);
    if (TICK_CYCLES < 2 || TICK_CYCLES > 64'h0000_0000_FFFF_FFFF) begin : g_tick_range
        $error("TICK_CYCLES out of range");
    end

    // Reset release through two flip-flops
    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    wire rst_i_n = rst_sync_r;

    // AHB-Lite address phase capture
    logic        wr_pend_r;
    logic [7:0]  wr_idx_r;
    wire         addr_take = hsel && hready && htrans[1];
    wire  [7:0]  addr_idx  = haddr[9:2];
    // hsize is not decoded: every register is one whole word
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 8'h00;
        end else begin
            wr_pend_r <= addr_take && hwrite;
            wr_idx_r  <= addr_idx;
        end
    end
    wire [7:0] wdat = hwdata[7:0];
    wire wr_sec  = wr_pend_r && (wr_idx_r == rtc_count_pkg::IDX_SECONDS);
    wire wr_min  = wr_pend_r && (wr_idx_r == rtc_count_pkg::IDX_MINUTES);
    wire wr_hour = wr_pend_r && (wr_idx_r == rtc_count_pkg::IDX_HOURS);
    wire wr_day  = wr_pend_r && (wr_idx_r == rtc_count_pkg::IDX_DAY);
    wire wr_wday = wr_pend_r && (wr_idx_r == rtc_count_pkg::IDX_WEEKDAY);
    wire wr_mon  = wr_pend_r && (wr_idx_r == rtc_count_pkg::IDX_MONTH);
    wire wr_year = wr_pend_r && (wr_idx_r == rtc_count_pkg::IDX_YEAR);
    wire wr_ctrl = wr_pend_r && (wr_idx_r == rtc_count_pkg::IDX_TICK_CTRL);

    // Counter registers
    logic [7:0] sec_r;
    logic [7:0] min_r;
    logic [7:0] hour_r;
    logic [7:0] day_r;
    logic [2:0] wday_r;
    logic [7:0] mon_r;
    logic [7:0] year_r;
    logic       tick_en_r;

    // One-second divider, restarted whenever seconds are written
    logic [31:0] div_r;
    logic        tick_r;
    wire  [31:0] div_last = 32'(TICK_CYCLES - 1);
    wire         div_end  = (div_r == div_last);
    wire  [31:0] div_nxt  = (div_end || wr_sec || !tick_en_r) ? 32'h0000_0000
                                                              : 32'(div_r + 32'h0000_0001);
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            div_r  <= 32'h0000_0000;
            tick_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            tick_r <= div_end && tick_en_r && !wr_sec;
        end
    end

    // Per-counter step logic
    wire [7:0] sec_step;
    wire [7:0] min_step;
    wire [7:0] h24_step;
    wire [7:0] h12_step;
    wire [7:0] day_step;
    wire [7:0] mon_step;
    wire [7:0] year_step;
    wire       sec_wrap;
    wire       min_wrap;
    wire       h24_wrap;
    wire       day_wrap;
    wire       mon_wrap;

    // Month length with leap-year February
    // Leap test on BCD: odd tens digit needs units 2 or 6, even tens 0, 4 or 8
    wire       leap       = (year_r[4] ? (year_r[1:0] == 2'h2) : (year_r[1:0] == 2'h0));
    wire       mon_short  = (mon_r == 8'h04) || (mon_r == 8'h06) || (mon_r == 8'h09)
                            || (mon_r == 8'h11);
    wire [7:0] day_max    = (mon_r == rtc_count_pkg::MONTH_FEB)
                            ? (leap ? rtc_count_pkg::BCD_29 : rtc_count_pkg::BCD_28)
                            : (mon_short ? rtc_count_pkg::BCD_30 : rtc_count_pkg::BCD_31);

    bcd_digit_step u_sec (
        .value      (sec_r),
        .max_value  (rtc_count_pkg::BCD_59),
        .min_value  (8'h00),
        .next_value (sec_step),
        .wrap       (sec_wrap)
    );
    bcd_digit_step u_min (
        .value      (min_r),
        .max_value  (rtc_count_pkg::BCD_59),
        .min_value  (8'h00),
        .next_value (min_step),
        .wrap       (min_wrap)
    );
    bcd_digit_step u_h24 (
        .value      ({2'b00, hour_r[5:0]}),
        .max_value  (rtc_count_pkg::BCD_23),
        .min_value  (8'h00),
        .next_value (h24_step),
        .wrap       (h24_wrap)
    );
    bcd_digit_step u_h12 (
        .value      ({3'b000, hour_r[4:0]}),
        .max_value  (rtc_count_pkg::BCD_12),
        .min_value  (8'h01),
        .next_value (h12_step),
        .wrap       ()
    );
    bcd_digit_step u_day (
        .value      (day_r),
        .max_value  (day_max),
        .min_value  (8'h01),
        .next_value (day_step),
        .wrap       (day_wrap)
    );
    bcd_digit_step u_mon (
        .value      (mon_r),
        .max_value  (rtc_count_pkg::BCD_12),
        .min_value  (8'h01),
        .next_value (mon_step),
        .wrap       (mon_wrap)
    );
    bcd_digit_step u_year (
        .value      (year_r),
        .max_value  (rtc_count_pkg::BCD_79),
        .min_value  (8'h00),
        .next_value (year_step),
        .wrap       ()
    );

    // Carry chain
    wire       mode12    = hour_r[rtc_count_pkg::HOUR_MODE_BIT];
    wire       pm        = hour_r[rtc_count_pkg::HOUR_PM_BIT];
    wire       h12_at11  = ({3'b000, hour_r[4:0]} == rtc_count_pkg::BCD_11);
    wire       c_min     = tick_r && sec_wrap;
    wire       c_hour    = c_min && min_wrap;
    wire       c_day     = c_hour && (mode12 ? (h12_at11 && pm) : h24_wrap);
    wire       c_mon     = c_day && day_wrap;
    wire       c_year    = c_mon && mon_wrap;
    wire       pm_nxt    = h12_at11 ? !pm : pm;
    wire [7:0] hour_step = mode12 ? {1'b0, 1'b1, pm_nxt, h12_step[4:0]}
                                  : {1'b0, 1'b0, h24_step[5:0]};
    // A day carry also steps the weekday, 7 wrapping to 1
    wire [2:0] wday_step = (wday_r >= rtc_count_pkg::WEEKDAY_MAX)
                           ? 3'h1 : 3'(wday_r + 3'h1);

    // Software writes take precedence over a coinciding count step
    wire [7:0] sec_nxt  = wr_sec  ? (wdat & rtc_count_pkg::MASK_SECONDS)
                                  : (tick_r ? sec_step : sec_r);
    wire [7:0] min_nxt  = wr_min  ? (wdat & rtc_count_pkg::MASK_MINUTES)
                                  : (c_min ? min_step : min_r);
    wire [7:0] hour_nxt = wr_hour ? (wdat & rtc_count_pkg::MASK_HOURS)
                                  : (c_hour ? hour_step : hour_r);
    wire [7:0] day_nxt  = wr_day  ? (wdat & rtc_count_pkg::MASK_DAY)
                                  : (c_day ? day_step : day_r);
    wire [2:0] wday_nxt = wr_wday ? wdat[2:0] : (c_day ? wday_step : wday_r);
    wire [7:0] mon_nxt  = wr_mon  ? (wdat & rtc_count_pkg::MASK_MONTH)
                                  : (c_mon ? mon_step : mon_r);
    wire [7:0] year_nxt = wr_year ? (wdat & rtc_count_pkg::MASK_YEAR)
                                  : (c_year ? year_step : year_r);
    wire       tick_en_nxt = wr_ctrl ? wdat[0] : tick_en_r;

    // One short flop block per counter, each beside its reset value
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            sec_r <= rtc_count_pkg::RST_SECONDS;
        end else begin
            sec_r <= sec_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            min_r <= rtc_count_pkg::RST_MINUTES;
        end else begin
            min_r <= min_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            hour_r <= rtc_count_pkg::RST_HOURS;
        end else begin
            hour_r <= hour_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            day_r <= rtc_count_pkg::RST_DAY;
        end else begin
            day_r <= day_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            wday_r <= rtc_count_pkg::RST_WEEKDAY;
        end else begin
            wday_r <= wday_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            mon_r <= rtc_count_pkg::RST_MONTH;
        end else begin
            mon_r <= mon_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            year_r <= rtc_count_pkg::RST_YEAR;
        end else begin
            year_r <= year_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            tick_en_r <= rtc_count_pkg::RST_TICK_EN;
        end else begin
            tick_en_r <= tick_en_nxt;
        end
    end

    // Read mux; unimplemented bits and unmapped indexes read zero
    wire [7:0] rd_byte =
        (addr_idx == rtc_count_pkg::IDX_SECONDS)   ? sec_nxt  :
        (addr_idx == rtc_count_pkg::IDX_MINUTES)   ? min_nxt  :
        (addr_idx == rtc_count_pkg::IDX_HOURS)     ? hour_nxt :
        (addr_idx == rtc_count_pkg::IDX_DAY)       ? day_nxt  :
        (addr_idx == rtc_count_pkg::IDX_WEEKDAY)   ? {5'h00, wday_nxt} :
        (addr_idx == rtc_count_pkg::IDX_MONTH)     ? mon_nxt  :
        (addr_idx == rtc_count_pkg::IDX_YEAR)      ? year_nxt :
        (addr_idx == rtc_count_pkg::IDX_TICK_CTRL) ? {7'h00, tick_en_nxt} :
        8'h00;
    wire rd_take = addr_take && !hwrite;

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            second_tick <= 1'b0;
        end else begin
            hrdata      <= rd_take ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            second_tick <= tick_r;
        end
    end
endmodule
`default_nettype wire

// ### logic/rtc_count_pkg.sv
// Package of offsets, field layouts, reset values and timing for the BCD time counters
package rtc_count_pkg;

    // Register offsets are not all multiples of four: they are word indexes
    localparam logic [7:0] IDX_SECONDS     = 8'h08;
    localparam logic [7:0] IDX_MINUTES     = 8'h09;
    localparam logic [7:0] IDX_HOURS       = 8'h0A;
    localparam logic [7:0] IDX_DAY         = 8'h0B;
    localparam logic [7:0] IDX_WEEKDAY     = 8'h0C;
    localparam logic [7:0] IDX_MONTH       = 8'h0D;
    localparam logic [7:0] IDX_YEAR        = 8'h0E;
    localparam logic [7:0] IDX_TICK_CTRL   = 8'h0F;

    // Field masks of implemented bits
    localparam logic [7:0] MASK_SECONDS    = 8'h7F;
    localparam logic [7:0] MASK_MINUTES    = 8'h7F;
    localparam logic [7:0] MASK_HOURS      = 8'h7F;
    localparam logic [7:0] MASK_DAY        = 8'h3F;
    localparam logic [7:0] MASK_WEEKDAY    = 8'h07;
    localparam logic [7:0] MASK_MONTH      = 8'h1F;
    localparam logic [7:0] MASK_YEAR       = 8'h7F;

    // Hours field positions
    localparam int HOUR_MODE_BIT           = 6;
    localparam int HOUR_PM_BIT             = 5;

    // Limits in BCD
    localparam logic [7:0] BCD_59          = 8'h59;
    localparam logic [7:0] BCD_23          = 8'h23;
    localparam logic [7:0] BCD_12          = 8'h12;
    localparam logic [7:0] BCD_11          = 8'h11;
    localparam logic [7:0] BCD_79          = 8'h79;
    localparam logic [7:0] BCD_31          = 8'h31;
    localparam logic [7:0] BCD_30          = 8'h30;
    localparam logic [7:0] BCD_29          = 8'h29;
    localparam logic [7:0] BCD_28          = 8'h28;
    localparam logic [7:0] MONTH_FEB       = 8'h02;
    localparam logic [2:0] WEEKDAY_MAX     = 3'h7;

    // Reset values: 00:00:00 24-hour, day 1, Sunday, January, year 00
    localparam logic [7:0] RST_SECONDS     = 8'h00;
    localparam logic [7:0] RST_MINUTES     = 8'h00;
    localparam logic [7:0] RST_HOURS       = 8'h00;
    localparam logic [7:0] RST_DAY         = 8'h01;
    localparam logic [2:0] RST_WEEKDAY     = 3'h1;
    localparam logic [7:0] RST_MONTH       = 8'h01;
    localparam logic [7:0] RST_YEAR        = 8'h00;
    localparam logic       RST_TICK_EN     = 1'b1;

    // Tick timing
    localparam longint CLK_HZ              = 100000000;
    localparam longint TICK_PERIOD_S       = 1;
    localparam longint TICK_CYCLES         = CLK_HZ * TICK_PERIOD_S;

    // AHB-Lite codes
    localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0] HTRANS_SEQ      = 2'h3;
    localparam logic [2:0] HSIZE_WORD      = 3'h2;

endpackage

// ### verification/bcd_time_of_day_counters_checker.sv
// Checker of bus answers and read-back ranges of the BCD time counters
`timescale 1ns/1ps
`default_nettype none
module bcd_time_of_day_counters_checker #(
    parameter longint TICK_CYCLES = rtc_count_pkg::TICK_CYCLES
) (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        second_tick
);
    logic      rd_q;
    logic [7:0] idx_q;
    longint    gap_r;
    wire logic taken = hsel && hready && htrans[1];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Remembers the address phase so the data phase can be judged
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_q  <= 1'b0;
            idx_q <= 8'h00;
            gap_r <= 0;
        end else begin
            rd_q  <= taken && !hwrite;
            idx_q <= haddr[9:2];
            gap_r <= second_tick ? 1 : gap_r + 1;
        end
    end
    function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
        return v[3:0] <= 4'h9 && v >= lo && v <= hi;
    endfunction
    AST_BUS_READY: assert property (hreadyout && !hresp)
        else $error("slave inserted a wait state or an error response");
    AST_IDLE_DATA: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("read data present outside a read data phase");
    AST_UPPER_ZERO: assert property (rd_q |-> hrdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    AST_SEC_RANGE: assert property (rd_q && idx_q == rtc_count_pkg::IDX_SECONDS
        |-> bcd_in(hrdata[7:0], 8'h00, 8'h59))
        else $error("seconds read outside BCD 0 to 59");
    AST_MIN_RANGE: assert property (rd_q && idx_q == rtc_count_pkg::IDX_MINUTES
        |-> bcd_in(hrdata[7:0], 8'h00, 8'h59))
        else $error("minutes read outside BCD 0 to 59");
    AST_HOUR_RANGE: assert property (rd_q && idx_q == rtc_count_pkg::IDX_HOURS
        |-> !hrdata[7] && (hrdata[6] ? bcd_in({3'h0, hrdata[4:0]}, 8'h01, 8'h12)
                                     : bcd_in({2'h0, hrdata[5:0]}, 8'h00, 8'h23)))
        else $error("hours read outside the range of its mode");
    AST_DAY_RANGE: assert property (rd_q && idx_q == rtc_count_pkg::IDX_DAY
        |-> bcd_in(hrdata[7:0], 8'h01, 8'h31))
        else $error("day read outside BCD 1 to 31");
    AST_WDAY_RANGE: assert property (rd_q && idx_q == rtc_count_pkg::IDX_WEEKDAY
        |-> hrdata[7:0] inside {[8'h01:8'h07]})
        else $error("weekday read outside 1 to 7");
    AST_TICK_GAP: assert property (second_tick |-> gap_r >= TICK_CYCLES && !$past(second_tick))
        else $error("seconds stepped sooner than one tick period");
    COV_WRITE: cover property (taken && hwrite);
    COV_TICK: cover property (second_tick);
    COV_HOUR12: cover property (rd_q && idx_q == rtc_count_pkg::IDX_HOURS && hrdata[6]);
endmodule
bind bcd_time_of_day_counters bcd_time_of_day_counters_checker #(
    .TICK_CYCLES(TICK_CYCLES)
) u_checker (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .second_tick(second_tick));
`default_nettype wire

// ### verification/test_bcd_time_of_day_counters.sv
// Self-checking testbench of the BCD time counters over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module test_bcd_time_of_day_counters;
    localparam longint TICK = 10;
    localparam int     LIMIT = 20000;
    // Corners {year, month, weekday, day, hours, minutes, seconds}
    localparam logic [55:0] CORNER [5] = '{56'h0002072823_5959, 56'h0102032823_5959,
        56'h7912053171_5959, 56'h1506041551_5959, 56'h1506041552_5959};
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = rtc_count_pkg::HSIZE_WORD;
    wire logic [31:0] hrdata;
    wire logic   hready;
    wire logic   second_tick;
    int          err_count = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          k;
    logic [7:0]  st [7];
    logic [7:0]  exp_st [7];
    logic [31:0] rd;
    bcd_time_of_day_counters #(.TICK_CYCLES(TICK)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(),
        .second_tick(second_tick));
    always #5 clk_sys = ~clk_sys;
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdv);
        @(posedge clk_sys);
        hsel <= 1'h1;
        htrans <= rtc_count_pkg::HTRANS_NONSEQ;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        @(posedge clk_sys);
        while (hready !== 1'h1) @(posedge clk_sys);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hready !== 1'h1) @(posedge clk_sys);
        rdv = hrdata;
    endtask
    function automatic int bi(input logic [7:0] v);
        return v[7:4] * 10 + v[3:0];
    endfunction
    function automatic logic [7:0] ib(input int n);
        return 8'((n / 10) * 16 + n % 10);
    endfunction
    function automatic int mlen(input logic [7:0] m, input logic [7:0] y);
        case (bi(m))
            2: return (bi(y) % 4 == 0) ? 29 : 28;
            4, 6, 9, 11: return 30;
            default: return 31;
        endcase
    endfunction
    // Expected counters after one second step
    function automatic void step();
        int   h;
        logic pm;
        logic c;
        exp_st = st;
        c = 1'h0;
        exp_st[0] = ib((bi(st[0]) + 1) % 60);
        if (bi(st[0]) == 59) exp_st[1] = ib((bi(st[1]) + 1) % 60);
        if (bi(st[0]) == 59 && bi(st[1]) == 59) begin
            if (st[2][6]) begin
                h = bi({3'h0, st[2][4:0]});
                pm = st[2][5] ^ (h == 11);
                c = (h == 11) && st[2][5];
                exp_st[2] = ib(h == 12 ? 1 : h + 1) | {2'h1, pm, 5'h0};
            end else begin
                c = (bi(st[2]) == 23);
                exp_st[2] = ib((bi(st[2]) + 1) % 24);
            end
        end
        if (c) begin
            exp_st[4] = (st[4] == 8'h07) ? 8'h01 : st[4] + 8'h01;
            exp_st[3] = ib(bi(st[3]) + 1);
            if (bi(st[3]) == mlen(st[5], st[6])) begin
                exp_st[3] = 8'h01;
                exp_st[5] = (st[5] == 8'h12) ? 8'h01 : ib(bi(st[5]) + 1);
                if (st[5] == 8'h12) exp_st[6] = ib((bi(st[6]) + 1) % 80);
            end
        end
    endfunction
    task automatic pick();
        int h;
        st[0] = 8'h59;
        st[1] = $urandom_range(1) ? 8'h59 : ib($urandom_range(59));
        h = $urandom_range(1) ? 11 : $urandom_range(12, 1);
        if ($urandom_range(1)) st[2] = ib(h) | {2'h1, 1'($urandom_range(1)), 5'h0};
        else st[2] = $urandom_range(1) ? 8'h23 : ib($urandom_range(23));
        st[6] = ib($urandom_range(79));
        st[5] = ib($urandom_range(12, 1));
        h = mlen(st[5], st[6]);
        st[3] = $urandom_range(1) ? ib(h) : ib($urandom_range(h, 1));
        st[4] = 8'($urandom_range(7, 1));
    endtask
    initial begin
        void'($urandom(36));
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk_sys);
        exp_st = '{rtc_count_pkg::RST_SECONDS, rtc_count_pkg::RST_MINUTES,
            rtc_count_pkg::RST_HOURS, rtc_count_pkg::RST_DAY,
            {5'h0, rtc_count_pkg::RST_WEEKDAY}, rtc_count_pkg::RST_MONTH,
            rtc_count_pkg::RST_YEAR};
        for (int i = 0; i < 7; i++) begin
            bus(1'h0, rtc_count_pkg::IDX_SECONDS + 8'(i), 32'h0, rd);
            check($sformatf("reset %0d", i), rd, 32'(exp_st[i]));
        end
        bus(1'h1, rtc_count_pkg::IDX_TICK_CTRL, 32'h0, rd);
        st = '{8'hD9, 8'hB0, 8'h92, 8'hC5, 8'hFB, 8'hE9, 8'hC4};
        exp_st = '{8'h59, 8'h30, 8'h12, 8'h05, 8'h03, 8'h09, 8'h44};
        for (int i = 0; i < 7; i++) begin
            bus(1'h1, rtc_count_pkg::IDX_SECONDS + 8'(i), {24'hFFFFFF, st[i]}, rd);
            bus(1'h0, rtc_count_pkg::IDX_SECONDS + 8'(i), 32'h0, rd);
            check($sformatf("unused bits index %0d", i), rd, {24'h0, exp_st[i]});
        end
        bus(1'h0, 8'h10, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
        for (int n = 0; n < 45; n++) begin
            if (n < 5) for (int i = 0; i < 7; i++) st[i] = CORNER[n][8*i +: 8];
            else pick();
            step();
            for (int i = 6; i >= 0; i--) begin
                bus(1'h1, rtc_count_pkg::IDX_SECONDS + 8'(i), {24'h0, st[i]}, rd);
            end
            bus(1'h1, rtc_count_pkg::IDX_TICK_CTRL, 32'h1, rd);
            k = 0;
            while (second_tick !== 1'h1 && k < 100) begin
                @(posedge clk_sys);
                k++;
            end
            check("second tick", {31'h0, second_tick}, 32'h1);
            bus(1'h1, rtc_count_pkg::IDX_TICK_CTRL, 32'h0, rd);
            for (int i = 0; i < 7; i++) begin
                bus(1'h0, rtc_count_pkg::IDX_SECONDS + 8'(i), 32'h0, rd);
                check($sformatf("step %0d/%0d", n, i), rd, 32'(exp_st[i]));
            end
        end
        wrap_up();
    end
endmodule
`default_nettype wire
